// >>> hw/mdsl_line_ctrl.v
// Notes on behaviour
// - reset leaves DTR low, driver enabled
// - master DTR low reinitialises slave protocol
// - after reinit: offline, driver off, listening
// - only matching address brings slave on-line
// - compare received bytes against own address
// - own address decoded: drop DTR, enable driver
// - then assert RTS toward master
// - RTS looped back as own CTS
// - on-line sense readable at status bit 7
// - sense reads 1 on-line, 0 all off-line
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "mdsl_map.vh"

module mdsl_line_ctrl #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input  wire              clock,
    input  wire              reset_n,
    // wishbone classic slave
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    // received characters from the serial receiver
    input  wire [ADDR_W-1:0] rxData,
    input  wire              rxValid,
    // line pins
    input  wire              masterDtrLine,
    input  wire              onlineSenseLine,
    output reg               dtrLine,
    output reg               lineDriverEn,
    output reg               requestSendLine,
    output reg               clearSendLine,
    // interrupt
    output reg               irq
);

    // ****************************************
    // state codes
    // ****************************************
    // powerup: driver enabled as after reset, waiting for software
    localparam [2:0] ST_POWERUP = 3'h0;
    // listen: off-line, driver off, receiver still hears the master
    localparam [2:0] ST_LISTEN  = 3'h1;
    // enable: driver switched on, RTS not yet raised
    localparam [2:0] ST_ENABLE  = 3'h2;
    // online: RTS up, transmitter cleared to send
    localparam [2:0] ST_ONLINE  = 3'h3;
    // drop: RTS withdrawn before the driver is released
    localparam [2:0] ST_DROP    = 3'h4;

    // ****************************************
    // declarations
    // ****************************************
    reg  [2:0]              state_q;     // line control state
    reg  [2:0]              state_d;     // next state
    reg  [ADDR_W-1:0]       ownAddr_q;   // this slave's unique address
    reg                     listen_q;    // address matching allowed
    reg  [`MDSL_EV_W-1:0]   intStat_q;   // sticky event bits
    reg  [`MDSL_EV_W-1:0]   intStat_d;   // next sticky bits
    reg  [`MDSL_EV_W-1:0]   intMask_q;   // interrupt enables
    reg  [`MDSL_EV_W-1:0]   events;      // this cycle's events
    reg  [31:0]             readData;    // decoded read value
    reg                     dtr_d;       // next DTR level
    reg                     rts_d;       // next RTS level
    reg                     dtrReinit_q; // delayed reinit level
    wire [1:0]              pinSync;     // synchronised pins
    wire                    reinitLvl;   // master holds its DTR low
    wire                    senseLvl;    // some slave is on-line
    wire                    access;      // new bus request this cycle
    wire                    wrLow;       // write hitting byte lane 0
    wire                    cmdRaise;    // software raises DTR
    wire                    cmdOffline;  // software leaves the line
    wire                    addrHit;     // own address received

    // ****************************************
    // pin synchronisers
    // ****************************************
    // both pins come from other boards, so two flops before use
    mdsl_sync #(
        .WIDTH   (2)
    ) u_pinSync (
        .clock   (clock),
        .reset_n (reset_n),
        .async_i ({onlineSenseLine, masterDtrLine}),
        .sync_o  (pinSync)
    );

    // master DTR low is seen here as data set ready
    assign reinitLvl = ~pinSync[0];
    // the sense line is the wired RTS of whichever slave is on-line
    assign senseLvl  = ~pinSync[1];

    // ****************************************
    // bus decode
    // ****************************************
    // one request per bus cycle: ack blocks a second take
    // writes land on the taking edge, the ack follows one cycle on,
    // so a master never sees an ack before its write has landed
    assign access     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // all registers are narrow and live in byte lane 0
    assign wrLow      = access & wb_we_i & wb_sel_i[0];
    assign cmdRaise   = wrLow & (wb_adr_i == `MDSL_OFF_CTRL)
                        & wb_dat_i[`MDSL_CTRL_RAISE];
    assign cmdOffline = wrLow & (wb_adr_i == `MDSL_OFF_CTRL)
                        & wb_dat_i[`MDSL_CTRL_OFFLINE];

    // ****************************************
    // address match
    // ****************************************
    // compare against own address
    assign addrHit = rxValid & listen_q & (rxData == ownAddr_q);

    // ****************************************
    // next state
    // ****************************************
    // reinit outranks everything, so the master can always
    // pull every slave back to a known state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_POWERUP: begin
                // driver is on here: software must raise DTR soon
                if (cmdRaise) begin
                    state_d = ST_LISTEN;
                end
            end
            ST_LISTEN: begin
                if (addrHit) begin
                    state_d = ST_ENABLE;
                end
            end
            ST_ENABLE: begin
                state_d = ST_ONLINE;
            end
            ST_ONLINE: begin
                // leave the line on command
                if (cmdOffline | cmdRaise) begin
                    state_d = ST_DROP;
                end
            end
            ST_DROP: begin
                state_d = ST_LISTEN;
            end
            default: begin
                state_d = ST_LISTEN;
            end
        endcase
        if (reinitLvl) begin
            state_d = ST_LISTEN;
        end
    end

    // ****************************************
    // line levels from the next state
    // ****************************************
    // decoded from state_d so the pins are flops yet in step
    always @* begin
        case (state_d)
            ST_POWERUP: begin
                dtr_d = 1'b0;
                rts_d = 1'b0;
            end
            ST_LISTEN: begin
                // only the driver is off, the receive path stays live
                dtr_d = 1'b1;
                rts_d = 1'b0;
            end
            ST_ONLINE: begin
                dtr_d = 1'b0;
                rts_d = 1'b1;
            end
            default: begin
                // enable and drop: driver on, RTS low
                dtr_d = 1'b0;
                rts_d = 1'b0;
            end
        endcase
    end

    // ****************************************
    // state and line flops
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q         <= ST_POWERUP;
            dtrLine         <= 1'b0;
            lineDriverEn    <= 1'b1;
            requestSendLine <= 1'b0;
            clearSendLine   <= 1'b0;
        end else begin
            state_q         <= state_d;
            dtrLine         <= dtr_d;
            lineDriverEn    <= ~dtr_d;
            // only raised when dtr_d is low, so a raised RTS
            // always has the driver behind it
            requestSendLine <= rts_d & ~dtr_d;
            clearSendLine   <= rts_d & ~dtr_d;
        end
    end

    // ****************************************
    // events
    // ****************************************
    // reinit is reported once, on the edge into the low level
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dtrReinit_q <= 1'b0;
        end else begin
            dtrReinit_q <= reinitLvl;
        end
    end

    // one-cycle event pulses feeding the sticky bits
    // a reinit that cuts an on-line slave reports both bits
    always @* begin
        events                  = {`MDSL_EV_W{1'b0}};
        events[`MDSL_EV_SELECT] = (state_q == ST_ENABLE) &
                                  (state_d == ST_ONLINE);
        events[`MDSL_EV_REINIT] = reinitLvl & ~dtrReinit_q;
        events[`MDSL_EV_DROP]   = (state_q == ST_ONLINE) &
                                  (state_d != ST_ONLINE);
    end

    // write-one-to-clear; a new event wins over the clear
    always @* begin
        intStat_d = intStat_q;
        if (wrLow && (wb_adr_i == `MDSL_OFF_INTSTAT)) begin
            intStat_d = intStat_q & ~wb_dat_i[`MDSL_EV_W-1:0];
        end
        intStat_d = intStat_d | events;
    end

    // ****************************************
    // software registers
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ownAddr_q <= `MDSL_RST_ADDR;
            listen_q  <= `MDSL_RST_LISTEN;
            intMask_q <= `MDSL_RST_MASK;
            intStat_q <= {`MDSL_EV_W{1'b0}};
            irq       <= 1'b0;
        end else begin
            intStat_q <= intStat_d;
            // level output, rises on the same edge as the sticky bit
            // because it is built from the next sticky value
            irq       <= |(intStat_d & intMask_q);
            if (wrLow) begin
                case (wb_adr_i)
                    `MDSL_OFF_CTRL: begin
                        // matching may be paused while software
                        // reprograms the address; every control
                        // write rewrites this bit, so software must
                        // set bit 2 with each command it issues
                        listen_q <= wb_dat_i[`MDSL_CTRL_LISTEN];
                    end
                    `MDSL_OFF_ADDR: begin
                        ownAddr_q <= wb_dat_i[ADDR_W-1:0];
                    end
                    `MDSL_OFF_INTMASK: begin
                        intMask_q <= wb_dat_i[`MDSL_EV_W-1:0];
                    end
                    default: begin
                        // status and unmapped: writes ignored
                    end
                endcase
            end
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    // reserved bits and unmapped offsets read as zero
    always @* begin
        readData = 32'h00000000;
        case (wb_adr_i)
            `MDSL_OFF_CTRL: begin
                readData[`MDSL_CTRL_LISTEN] = listen_q;
            end
            `MDSL_OFF_ADDR: begin
                readData[ADDR_W-1:0] = ownAddr_q;
            end
            `MDSL_OFF_STATUS: begin
                readData[`MDSL_ST_DTR] = dtrLine;
                readData[`MDSL_ST_RTS] = requestSendLine;
                readData[`MDSL_ST_DRV] = lineDriverEn;
                readData[`MDSL_ST_STATE_LO+2:`MDSL_ST_STATE_LO] = state_q;
                readData[`MDSL_ST_ONLINE] = senseLvl;
            end
            `MDSL_OFF_INTSTAT: begin
                readData[`MDSL_EV_W-1:0] = intStat_q;
            end
            `MDSL_OFF_INTMASK: begin
                readData[`MDSL_EV_W-1:0] = intMask_q;
            end
            default: begin
                readData = 32'h00000000;
            end
        endcase
    end

    // ****************************************
    // bus answer
    // ****************************************
    // every request, mapped or not, is answered one cycle later
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= access;
            // read data is captured on the taking edge and then held
            if (access && !wb_we_i) begin
                wb_dat_o <= readData;
            end
        end
    end

endmodule

// >>> hw/mdsl_map.vh
`ifndef MDSL_MAP_VH
`define MDSL_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define MDSL_OFF_CTRL     8'h00
`define MDSL_OFF_ADDR     8'h04
`define MDSL_OFF_STATUS   8'h08
`define MDSL_OFF_INTSTAT  8'h0C
`define MDSL_OFF_INTMASK  8'h10

// ****************************************
// control register bits (bits 0-1: write 1 = command; bit 2: stored listen level)
// ****************************************
`define MDSL_CTRL_RAISE   0
`define MDSL_CTRL_OFFLINE 1
`define MDSL_CTRL_LISTEN  2

// ****************************************
// status register bits
// ****************************************
`define MDSL_ST_DTR       0
`define MDSL_ST_RTS       1
`define MDSL_ST_DRV       2
`define MDSL_ST_STATE_LO  3
`define MDSL_ST_ONLINE    7

// ****************************************
// interrupt event bits
// ****************************************
`define MDSL_EV_SELECT    0
`define MDSL_EV_REINIT    1
`define MDSL_EV_DROP      2
`define MDSL_EV_W         3

// ****************************************
// reset values
// ****************************************
`define MDSL_RST_ADDR     8'h00
`define MDSL_RST_LISTEN   1'b1
`define MDSL_RST_MASK     3'h0

`endif

// >>> hw/mdsl_sync.v
`timescale 1ns/1ps

// ****************************************
// two-stage level synchroniser
// ****************************************
module mdsl_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset_n,
    // asynchronous level in, synchronised level out
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    // first stage, read only by the second stage
    reg [WIDTH-1:0] meta_q;

    // both stages reset to the idle-high line level
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= {WIDTH{1'b1}};
            sync_o <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// >>> tb/mdsl_line_ctrl_assertions.sv
`timescale 1ns/1ps
// ****************************************
// line-control port checker
// ****************************************
module mdsl_line_ctrl_assertions (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // bus handshake
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // line pins
    input wire masterDtrLine,
    input wire dtrLine,
    input wire lineDriverEn,
    input wire requestSendLine,
    input wire clearSendLine
);
    // one domain, so reset aborts every check in flight
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_reset_driver_on: assert property (
        $rose(reset_n) |-> !dtrLine && lineDriverEn) else $error("driver off after reset");
    chk_driver_gate: assert property (
        lineDriverEn == !dtrLine) else $error("driver enable not tied to dtr");
    chk_cts_loop: assert property (
        clearSendLine == requestSendLine) else $error("cts differs from rts");
    chk_rts_needs_drv: assert property (
        $rose(requestSendLine) |-> $past(lineDriverEn) && lineDriverEn) else $error("rts early");
    chk_select_order: assert property (
        $fell(dtrLine) |=> requestSendLine) else $error("rts missing after dtr drop");
    // sync chain is two flops, so four low samples must show the offline state
    chk_reinit_offline: assert property (
        !masterDtrLine [*4] |-> dtrLine && !requestSendLine) else $error("reinit ignored");
    chk_drop_order: assert property (
        $fell(requestSendLine) |-> ##[0:1] dtrLine) else $error("dtr not raised on drop");
    chk_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
endmodule

bind mdsl_line_ctrl mdsl_line_ctrl_assertions chk_inst (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .masterDtrLine(masterDtrLine), .dtrLine(dtrLine), .lineDriverEn(lineDriverEn),
    .requestSendLine(requestSendLine), .clearSendLine(clearSendLine));

// >>> tb/mdsl_master_model.sv
`timescale 1ns/1ps
// ****************************************
// master station on the shared line
// ****************************************
module mdsl_master_model (
    // clock
    input  wire       clock,
    // slave side
    input  wire       requestSendLine,
    output reg        masterDtrLine,
    output wire       onlineSenseLine,
    output reg  [7:0] rxData,
    output reg        rxValid
);
    // wired sense
    // crossed wire, active low while a slave drives rts
    assign onlineSenseLine = ~requestSendLine;
    initial begin
        masterDtrLine = 1'b1;
        rxData = 8'h00;
        rxValid = 1'b0;
    end
    // address character
    // data is scrambled after the valid cycle so stale bytes never match
    task sendChar(input [7:0] c);
        begin
            @(posedge clock);
            rxData <= c;
            rxValid <= 1'b1;
            @(posedge clock);
            rxValid <= 1'b0;
            rxData <= ~c;
        end
    endtask
    task reinit(input integer n);
        begin
            @(posedge clock);
            masterDtrLine <= 1'b0;
            repeat (n) @(posedge clock);
            masterDtrLine <= 1'b1;
        end
    endtask
endmodule

// >>> tb/mdsl_line_ctrl_test.sv
`timescale 1ns/1ps
`include "mdsl_map.vh"
module mdsl_line_ctrl_test;
    reg         clock, reset_n, wbCyc, wbStb, wbWe;
    reg  [7:0]  wbAdr;
    reg  [3:0]  wbSel;
    reg  [31:0] wbDat, rd;
    wire [31:0] wbDatOut;
    wire        wbAck, masterDtr, senseLine, rxValid, dtrLine, drvEn, rts, cts, irq;
    wire [7:0]  rxData;
    // pins in one word: dtr, driver, rts, cts, irq
    wire [4:0]  pins = {dtrLine, drvEn, rts, cts, irq};
    integer     err_total, checks, cycles;
    mdsl_line_ctrl mdsl_line_ctrl_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .rxData(rxData), .rxValid(rxValid),
        .masterDtrLine(masterDtr), .onlineSenseLine(senseLine), .dtrLine(dtrLine),
        .lineDriverEn(drvEn), .requestSendLine(rts), .clearSendLine(cts), .irq(irq));
    mdsl_master_model mdsl_master_model_inst (.clock(clock), .requestSendLine(rts),
        .masterDtrLine(masterDtr), .onlineSenseLine(senseLine), .rxData(rxData),
        .rxValid(rxValid));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task wbXfer(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge clock);
            wbCyc <= 1'b1;
            wbStb <= 1'b1;
            wbWe <= w;
            wbAdr <= a;
            wbDat <= d;
            @(posedge clock);
            // no cycle count assumed: a wait ends on ack, or else at the hang guard
            while (wbAck !== 1'b1) begin
                @(posedge clock);
            end
            rd = wbDatOut;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            if (err_total == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // hang guard, far above the hundred or so cycles the sequence needs
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end
    initial begin
        reset_n = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'hF;
        wbDat = 32'h0;
        err_total = 0;
        checks = 0;
        cycles = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        check("pins", pins, 5'b01000);
        wbXfer(`MDSL_OFF_STATUS, 1'b0, 32'h0);
        check("status", rd & 32'hFF, 32'h04);
        // init raises dtr through the control port
        // bit 2 keeps address matching on, every control write sets it
        wbXfer(`MDSL_OFF_CTRL, 1'b1, 32'h5);
        wbXfer(`MDSL_OFF_STATUS, 1'b0, 32'h0);
        check("status", rd & 32'hFF, 32'h09);
        wbXfer(`MDSL_OFF_ADDR, 1'b1, 32'h5A);
        wbXfer(`MDSL_OFF_INTMASK, 1'b1, 32'h7);
        wbXfer(`MDSL_OFF_ADDR, 1'b0, 32'h0);
        check("addr", rd, 32'h5A);
        // a write without byte lane 0 must leave the address alone
        wbSel <= 4'hE;
        wbXfer(`MDSL_OFF_ADDR, 1'b1, 32'h33);
        wbSel <= 4'hF;
        wbXfer(`MDSL_OFF_ADDR, 1'b0, 32'h0);
        check("addr", rd, 32'h5A);
        wbXfer(`MDSL_OFF_CTRL, 1'b0, 32'h0);
        check("ctrl", rd, 32'h4);
        // near misses: one bit off, top bit off
        mdsl_master_model_inst.sendChar(8'h5B);
        mdsl_master_model_inst.sendChar(8'hDA);
        repeat (4) @(posedge clock);
        check("pins", pins, 5'b10000);
        mdsl_master_model_inst.sendChar(8'h5A);
        @(negedge clock);
        check("pins", pins, 5'b01000);
        @(negedge clock);
        check("pins", pins, 5'b01111);
        @(negedge clock);
        check("pins", pins, 5'b01111);
        repeat (4) @(posedge clock);
        wbXfer(`MDSL_OFF_STATUS, 1'b0, 32'h0);
        check("status", rd & 32'hFF, 32'h9E);
        wbXfer(`MDSL_OFF_INTSTAT, 1'b0, 32'h0);
        check("intstat", rd, 32'h1);
        wbXfer(`MDSL_OFF_INTSTAT, 1'b1, 32'h1);
        wbXfer(`MDSL_OFF_INTSTAT, 1'b0, 32'h0);
        check("intstat", rd, 32'h0);
        // software takes the slave off-line
        wbXfer(`MDSL_OFF_CTRL, 1'b1, 32'h6);
        repeat (6) @(posedge clock);
        wbXfer(`MDSL_OFF_STATUS, 1'b0, 32'h0);
        check("status", rd & 32'h87, 32'h01);
        check("pins", pins, 5'b10001);
        wbXfer(`MDSL_OFF_INTSTAT, 1'b1, 32'h7);
        // reselect, then the master resets every slave
        mdsl_master_model_inst.sendChar(8'h5A);
        repeat (4) @(posedge clock);
        check("pins", pins, 5'b01111);
        mdsl_master_model_inst.reinit(6);
        repeat (4) @(posedge clock);
        check("pins", pins, 5'b10001);
        wbXfer(`MDSL_OFF_INTSTAT, 1'b0, 32'h0);
        check("intstat", rd & 32'h3, 32'h3);
        mdsl_master_model_inst.sendChar(8'h5A);
        repeat (4) @(posedge clock);
        check("rts", pins & 5'b00110, 5'b00110);
        // raising dtr from on-line also leaves the line
        wbXfer(`MDSL_OFF_CTRL, 1'b1, 32'h5);
        @(negedge clock);
        check("pins", pins & 5'b11110, 5'b10000);
        // unmapped place reads zero and ignores writes
        wbXfer(8'h20, 1'b1, 32'hFF);
        wbXfer(8'h20, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        wbXfer(`MDSL_OFF_INTMASK, 1'b1, 32'h0);
        @(negedge clock);
        check("irq", irq, 1'b0);
        report_and_stop;
    end
endmodule
